// ==== ccg_pkg.sv ====
`default_nettype none
package ccg_pkg;
    // register indices and their 12-bit decoded byte addresses (index times four)
    localparam logic [31:0] CCG_PLL_CTL_IDX = 32'hFFFFF806;
    localparam logic [31:0] CCG_PCC_IDX = 32'hFFFFF828;
    localparam logic [31:0] CCG_MODE_IDX = 32'hFFFFF830;
    localparam logic [31:0] CCG_STAT_IDX = 32'hFFFFF831;
    localparam int CCG_DEC_W = 12;
    localparam logic [11:0] CCG_PLL_CTL_ADDR = 12'(CCG_PLL_CTL_IDX << 2);
    localparam logic [11:0] CCG_PCC_ADDR = 12'(CCG_PCC_IDX << 2);
    localparam logic [11:0] CCG_MODE_ADDR = 12'(CCG_MODE_IDX << 2);
    localparam logic [11:0] CCG_STAT_ADDR = 12'(CCG_STAT_IDX << 2);

    // reset values
    localparam logic [7:0] CCG_PLL_CTL_RST = 8'h01;
    localparam logic [7:0] CCG_PCC_RST = 8'h03;

    // pll_control fields
    localparam int CCG_PLL_RUN_BIT = 0;
    localparam int CCG_PLL_SEL_BIT = 1;
    localparam int CCG_RTO_STOP_BIT = 2;

    // processor_clock_register fields
    localparam int CCG_SUB_FB_OFF_BIT = 7;
    localparam int CCG_MAIN_STOP_BIT = 6;
    localparam int CCG_MAIN_FB_OFF_BIT = 5;
    localparam int CCG_CLS_BIT = 4;
    localparam int CCG_SEL_TOP_BIT = 3;
    localparam logic [2:0] CCG_SEL_MAX = 3'h5;

    // mode register fields: command in [1:0], clock-out enable in [4]
    localparam int CCG_SYSTEM_CLOCK_OUT_PIN_EN_BIT = 4;
    localparam logic [1:0] CCG_CMD_NONE = 2'h0;
    localparam logic [1:0] CCG_CMD_HALT = 2'h1;
    localparam logic [1:0] CCG_CMD_IDLE = 2'h2;
    localparam logic [1:0] CCG_CMD_STOP = 2'h3;

    // status register fields
    localparam int CCG_ST_CLS_BIT = 4;
    localparam int CCG_ST_OST_BIT = 5;
    localparam int CCG_ST_MULT_BIT = 6;
    localparam int CCG_ST_OSC_BIT = 7;

    // timing: fx runs at a quarter of the system clock; the pll multiplies by four
    localparam int CCG_PLL_MULT = 4;
    localparam logic [1:0] CCG_FX_DIV_LAST = 2'(CCG_PLL_MULT - 1);
    localparam int CCG_PERI_W = 10;
    localparam int CCG_OST_TICKS = 8192;

    // htrans codes
    localparam logic [1:0] CCG_HTRANS_NONSEQ = 2'h2;

    // power and clock states
    typedef enum logic [2:0] {
        CCG_ST_OSTC = 3'b000,
        CCG_ST_RUN = 3'b001,
        CCG_ST_HALT = 3'b010,
        CCG_ST_IDLE = 3'b011,
        CCG_ST_STOP = 3'b100,
        CCG_ST_SIDLE = 3'b101
    } ccg_state_t;
endpackage
`default_nettype wire

// ==== ccg_prescaler.sv ====
`default_nettype none
module ccg_prescaler #(
    parameter int W = 10
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // base tick and divided ticks
    input wire logic i_base,
    output logic [W:0] o_tick
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    // free counter advanced by the base tick
    always_comb begin
        cnt_nxt = cnt_r;
        if (i_base) begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // tick k fires once every 2**k base ticks
    assign o_tick[0] = i_base;
    genvar k;
    generate
        for (k = 1; k <= W; k++) begin : g_tick
            assign o_tick[k] = i_base & (&cnt_r[k-1:0]);
        end
    endgenerate
endmodule
`default_nettype wire

// ==== ccg_stab_timer.sv ====
`default_nettype none
module ccg_stab_timer #(
    parameter int COUNT = 8192
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // count control
    input wire logic i_run,
    input wire logic i_tick,
    output logic o_done
);
    localparam int CW = $clog2(COUNT + 1);
    localparam logic [CW-1:0] LAST = CW'(COUNT);
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;

    // counts oscillator ticks while running, cleared otherwise
    always_comb begin
        cnt_nxt = cnt_r;
        if (!i_run) begin
            cnt_nxt = '0;
        end else if (i_tick && cnt_r != LAST) begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign o_done = i_run & (cnt_r == LAST);
endmodule
`default_nettype wire

// ==== ccg_clock_ctrl.sv ====
`default_nettype none
module ccg_clock_ctrl import ccg_pkg::*; #(
    parameter int OST_TICKS = CCG_OST_TICKS
) (
    // clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    // ahb-lite slave
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    // subclock tick and wake-up event
    input wire logic I_SUB_TICK,
    input wire logic I_WAKE,
    // oscillator and pll controls
    output logic O_MAIN_OSC_EN,
    output logic O_MAIN_FB_OFF,
    output logic O_SUB_FB_OFF,
    output logic O_PLL_RUN,
    output logic O_PLL_MULT,
    output logic O_RTO_STOP,
    // clock enables to consumers
    output logic O_CPU_CLK_EN,
    output logic O_SYS_CLK_EN,
    output logic [CCG_PERI_W:0] O_PERI_CLK_EN,
    // clock output pin
    output logic O_SYSTEM_CLOCK_OUT_PIN_O,
    output logic O_SYSTEM_CLOCK_OUT_PIN_OE,
    // state
    output logic [2:0] O_PWR_STATE
);
    ccg_state_t state_r, state_nxt;
    logic [2:0] pll_r, pll_nxt;
    logic [7:0] pcc_r, pcc_nxt;
    logic cls_r, cls_nxt;
    logic system_clock_out_pin_en_r, system_clock_out_pin_en_nxt;
    logic [1:0] fxdiv_r, fxdiv_nxt;
    logic osc_r, osc_nxt;
    logic cpu_r, cpu_nxt;
    logic sys_r, sys_nxt;
    logic [CCG_PERI_W:0] peri_r, peri_nxt;
    logic pin_r, pin_nxt;
    logic wr_r, wr_nxt;
    logic [CCG_DEC_W-1:0] addr_r, addr_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic take;
    logic wr_lane0;
    logic [1:0] cmd;
    logic fx_tick;
    logic mult;
    logic fxx_base;
    logic [CCG_PERI_W:0] fxx_tick;
    logic sel_tick;
    logic ost_done;
    logic osc_want;
    logic cpu_want;
    logic sys_want;

    // address phase taken on a nonsequential transfer with the bus ready
    assign take = I_HSEL & (I_HTRANS == CCG_HTRANS_NONSEQ) & I_HREADY;
    // only byte lane 0 holds register bits
    assign wr_lane0 = wr_r & (addr_r[1:0] == 2'h0);
    assign cmd = (wr_lane0 && addr_r == CCG_MODE_ADDR) ? I_HWDATA[1:0] : CCG_CMD_NONE;

    // fx tick every fourth cycle; pll mode feeds every cycle
    // main clock ratio
    assign mult = pll_r[CCG_PLL_RUN_BIT] & pll_r[CCG_PLL_SEL_BIT];
    assign fx_tick = osc_r & (fxdiv_r == CCG_FX_DIV_LAST);
    assign fxx_base = osc_r & (mult | (fxdiv_r == CCG_FX_DIV_LAST));

    // prescaler for cpu selection and peripherals
    ccg_prescaler #(.W(CCG_PERI_W)) u_presc (
        .clk(I_CLK_SYS),
        .rst_n(I_RST_N),
        .i_base(fxx_base),
        .o_tick(fxx_tick)
    );

    // stabilization wait counted on fx even for an external clock
    ccg_stab_timer #(.COUNT(OST_TICKS)) u_ost (
        .clk(I_CLK_SYS),
        .rst_n(I_RST_N),
        .i_run(state_r == CCG_ST_OSTC),
        .i_tick(fx_tick),
        .o_done(ost_done)
    );

    // divider choice, or subclock once the cpu has moved over
    always_comb begin
        sel_tick = I_SUB_TICK;
        if (!cls_r) begin
            sel_tick = fxx_tick[pcc_r[2:0]];
        end
    end

    // power state sequencing
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            CCG_ST_OSTC: begin
                if (ost_done) begin
                    state_nxt = CCG_ST_RUN;
                end
            end
            CCG_ST_RUN: begin
                if (cmd == CCG_CMD_HALT) begin
                    state_nxt = CCG_ST_HALT;
                end else if (cmd == CCG_CMD_IDLE) begin
                    state_nxt = cls_r ? CCG_ST_SIDLE : CCG_ST_IDLE;
                end else if (cmd == CCG_CMD_STOP) begin
                    state_nxt = CCG_ST_STOP;
                end
            end
            CCG_ST_HALT, CCG_ST_IDLE, CCG_ST_SIDLE: begin
                if (I_WAKE) begin
                    state_nxt = CCG_ST_RUN;
                end
            end
            CCG_ST_STOP: begin
                if (I_WAKE) begin
                    state_nxt = CCG_ST_OSTC;
                end
            end
            default: state_nxt = CCG_ST_OSTC;
        endcase
    end

    // which clocks the next state lets run
    always_comb begin
        // main stop honoured only while the cpu is on the subclock
        osc_want = (state_nxt != CCG_ST_STOP) & ~(cls_nxt & pcc_nxt[CCG_MAIN_STOP_BIT]);
        cpu_want = (state_nxt == CCG_ST_RUN);
        // system clock in run and halt
        sys_want = (state_nxt == CCG_ST_RUN) | (state_nxt == CCG_ST_HALT);
    end

    // register writes, subclock switch and clock enables
    always_comb begin
        pll_nxt = pll_r;
        pcc_nxt = pcc_r;
        system_clock_out_pin_en_nxt = system_clock_out_pin_en_r;
        cls_nxt = cls_r;
        fxdiv_nxt = fxdiv_r + 2'h1;
        if (wr_lane0 && addr_r == CCG_PLL_CTL_ADDR) begin
            // only bits 2..0 stored; bit 3 and the top nibble dropped
            pll_nxt = I_HWDATA[2:0];
        end
        if (wr_lane0 && addr_r == CCG_PCC_ADDR) begin
            pcc_nxt[7:5] = I_HWDATA[7:5];
            pcc_nxt[CCG_SEL_TOP_BIT] = I_HWDATA[CCG_SEL_TOP_BIT];
            // prohibited divide codes leave the old ratio
            if (I_HWDATA[2:0] <= CCG_SEL_MAX) begin
                pcc_nxt[2:0] = I_HWDATA[2:0];
            end
        end
        if (wr_lane0 && addr_r == CCG_MODE_ADDR) begin
            // pin leaves input mode only when software asks
            system_clock_out_pin_en_nxt = I_HWDATA[CCG_SYSTEM_CLOCK_OUT_PIN_EN_BIT];
        end
        // cpu source follows the top select bit at a subclock edge
        if (I_SUB_TICK) begin
            cls_nxt = pcc_r[CCG_SEL_TOP_BIT];
        end
        if (!osc_r) begin
            fxdiv_nxt = 2'h0;
        end
        osc_nxt = osc_want;
        cpu_nxt = cpu_want & sel_tick;
        sys_nxt = sys_want & sel_tick;
        // prescaler outputs need run or halt and a running oscillator
        peri_nxt = (sys_want & osc_r) ? fxx_tick : '0;
        // pin toggles on system clock ticks, returns low when stopped
        pin_nxt = pin_r;
        if (!sys_want) begin
            pin_nxt = 1'b0;
        end else if (sel_tick) begin
            pin_nxt = ~pin_r;
        end
    end

    // bus phase capture and read data from next-state values
    always_comb begin
        wr_nxt = take & I_HWRITE;
        addr_nxt = take ? I_HADDR[CCG_DEC_W-1:0] : addr_r;
        rdata_nxt = rdata_r;
        if (take && !I_HWRITE) begin
            rdata_nxt = 32'h0;
            if (I_HADDR[CCG_DEC_W-1:0] == CCG_PLL_CTL_ADDR) begin
                rdata_nxt[2:0] = pll_nxt;
            end else if (I_HADDR[CCG_DEC_W-1:0] == CCG_PCC_ADDR) begin
                rdata_nxt[7:0] = pcc_nxt;
                rdata_nxt[CCG_CLS_BIT] = cls_nxt;
            end else if (I_HADDR[CCG_DEC_W-1:0] == CCG_MODE_ADDR) begin
                rdata_nxt[CCG_SYSTEM_CLOCK_OUT_PIN_EN_BIT] = system_clock_out_pin_en_nxt;
            end else if (I_HADDR[CCG_DEC_W-1:0] == CCG_STAT_ADDR) begin
                rdata_nxt[2:0] = state_nxt;
                rdata_nxt[CCG_ST_CLS_BIT] = cls_nxt;
                rdata_nxt[CCG_ST_OST_BIT] = (state_nxt == CCG_ST_OSTC);
                rdata_nxt[CCG_ST_MULT_BIT] = pll_nxt[CCG_PLL_RUN_BIT] & pll_nxt[CCG_PLL_SEL_BIT];
                rdata_nxt[CCG_ST_OSC_BIT] = osc_want;
            end
        end
    end

    // state registers
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state_r <= CCG_ST_OSTC;
            pll_r <= CCG_PLL_CTL_RST[2:0];
            pcc_r <= CCG_PCC_RST;
            cls_r <= 1'b0;
            system_clock_out_pin_en_r <= 1'b0;
            fxdiv_r <= 2'h0;
            osc_r <= 1'b0;
            cpu_r <= 1'b0;
            sys_r <= 1'b0;
            peri_r <= '0;
            pin_r <= 1'b0;
            wr_r <= 1'b0;
            addr_r <= '0;
            rdata_r <= 32'h0;
        end else begin
            state_r <= state_nxt;
            pll_r <= pll_nxt;
            pcc_r <= pcc_nxt;
            cls_r <= cls_nxt;
            system_clock_out_pin_en_r <= system_clock_out_pin_en_nxt;
            fxdiv_r <= fxdiv_nxt;
            osc_r <= osc_nxt;
            cpu_r <= cpu_nxt;
            sys_r <= sys_nxt;
            peri_r <= peri_nxt;
            pin_r <= pin_nxt;
            wr_r <= wr_nxt;
            addr_r <= addr_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // outputs
    assign O_HRDATA = rdata_r;
    assign O_HREADYOUT = 1'b1; // zero-wait slave
    assign O_HRESP = 1'b0;
    assign O_MAIN_OSC_EN = osc_r;
    assign O_MAIN_FB_OFF = pcc_r[CCG_MAIN_FB_OFF_BIT];
    assign O_SUB_FB_OFF = pcc_r[CCG_SUB_FB_OFF_BIT];
    // pll may stay on through idle; it needs the oscillator
    assign O_PLL_RUN = pll_r[CCG_PLL_RUN_BIT] & osc_r;
    assign O_PLL_MULT = mult;
    assign O_RTO_STOP = pll_r[CCG_RTO_STOP_BIT];
    assign O_CPU_CLK_EN = cpu_r;
    assign O_SYS_CLK_EN = sys_r;
    assign O_PERI_CLK_EN = peri_r;
    // high impedance until clock output is configured
    assign O_SYSTEM_CLOCK_OUT_PIN_O = pin_r & system_clock_out_pin_en_r;
    assign O_SYSTEM_CLOCK_OUT_PIN_OE = system_clock_out_pin_en_r;
    assign O_PWR_STATE = state_r;
endmodule
`default_nettype wire

// ==== ccg_checker.sv ====
`default_nettype none
module ccg_checker import ccg_pkg::*; (
    // clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    // watched outputs
    input wire logic O_HREADYOUT,
    input wire logic O_HRESP,
    input wire logic O_MAIN_OSC_EN,
    input wire logic O_PLL_RUN,
    input wire logic O_PLL_MULT,
    input wire logic O_CPU_CLK_EN,
    input wire logic O_SYS_CLK_EN,
    input wire logic [CCG_PERI_W:0] O_PERI_CLK_EN,
    input wire logic O_SYSTEM_CLOCK_OUT_PIN_O,
    input wire logic [2:0] O_PWR_STATE
);
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_N);
    logic run, rh, off, stp, osc_on;
    // state groups used by the gating checks
    assign run = O_PWR_STATE == CCG_ST_RUN;
    assign rh = run || O_PWR_STATE == CCG_ST_HALT;
    assign off = O_PWR_STATE inside {CCG_ST_IDLE, CCG_ST_STOP, CCG_ST_SIDLE};
    assign stp = off || O_PWR_STATE == CCG_ST_OSTC;
    assign osc_on = O_PWR_STATE inside {CCG_ST_OSTC, CCG_ST_HALT, CCG_ST_IDLE};
    // gating relations; the stop, oscillator, peripheral-off and pin checks wait three settled cycles in a state
    bus_okay_a: assert property (O_HREADYOUT && !O_HRESP)
        else $error("bus answer not ready or not okay");
    cpu_gate_a: assert property (O_CPU_CLK_EN |-> run || $past(run))
        else $error("cpu tick outside run");
    sys_gate_a: assert property (O_SYS_CLK_EN |-> rh || $past(rh))
        else $error("system tick outside run or halt");
    osc_stop_a: assert property ((O_PWR_STATE == CCG_ST_STOP) [*3] |-> !O_MAIN_OSC_EN)
        else $error("oscillator running in stop");
    osc_run_a: assert property (osc_on [*3] |-> O_MAIN_OSC_EN)
        else $error("oscillator stopped while needed");
    peri_off_a: assert property (off [*3] |-> O_PERI_CLK_EN == '0)
        else $error("peripheral tick while idle or stopped");
    peri_osc_a: assert property (|O_PERI_CLK_EN |-> $past(O_MAIN_OSC_EN))
        else $error("peripheral tick without oscillator");
    pin_low_a: assert property (stp [*3] |-> !O_SYSTEM_CLOCK_OUT_PIN_O)
        else $error("clock pin high while system clock stopped");
    pll_mult_a: assert property (O_PLL_MULT |-> O_PLL_RUN && O_MAIN_OSC_EN)
        else $error("multiplied clock without running pll");
    // main scenarios reached
    halt_c: cover property (O_PWR_STATE == CCG_ST_HALT && O_SYS_CLK_EN);
    stop_c: cover property (O_PWR_STATE == CCG_ST_STOP);
    sidle_c: cover property (O_PWR_STATE == CCG_ST_SIDLE);
    mult_c: cover property (O_PLL_MULT && O_SYS_CLK_EN);
endmodule
`default_nettype wire

// ==== ccg_osc_model.sv ====
`default_nettype none
module ccg_osc_model (
    // system clock
    input wire logic clk,
    // subclock rate: slow or prompt
    input wire logic i_slow,
    // subclock tick toward the block
    output logic o_sub_tick
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [5:0] cnt_r = 6'h00;
    logic [5:0] cnt_nxt;
    logic tick_r = 1'b0;
    logic tick_nxt;
    // subclock runs in every state, reset included, so it has no reset
    always_comb begin
        cnt_nxt = (cnt_r >= (i_slow ? 6'h27 : 6'h04)) ? 6'h00 : cnt_r + 6'h01;
        tick_nxt = cnt_r == 6'h00;
    end
    always_ff @(posedge clk) begin
        cnt_r <= cnt_nxt;
        tick_r <= tick_nxt;
    end
    assign o_sub_tick = tick_r;
endmodule
`default_nettype wire

// ==== clock_gating_and_pll_control_tb.sv ====
`default_nettype none
module clock_gating_and_pll_control_tb import ccg_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {logic [1:0] k; logic [31:0] m; logic [31:0] e;} ccg_chk_t;
    logic I_CLK_SYS = 1'b0, I_RST_N = 1'b0, I_HSEL = 1'b0, I_HWRITE = 1'b0, I_WAKE = 1'b0;
    logic slow = 1'b1, rdp = 1'b0, I_SUB_TICK;
    logic [1:0] I_HTRANS = 2'h0;
    logic [2:0] I_HSIZE = 3'h2;
    logic [31:0] I_HADDR = 32'h0, I_HWDATA = 32'h0, O_HRDATA;
    logic O_HREADYOUT, O_HRESP, O_MAIN_OSC_EN, O_MAIN_FB_OFF, O_SUB_FB_OFF, O_PLL_RUN, O_PLL_MULT;
    logic O_RTO_STOP, O_CPU_CLK_EN, O_SYS_CLK_EN, O_SYSTEM_CLOCK_OUT_PIN_O, O_SYSTEM_CLOCK_OUT_PIN_OE;
    logic [CCG_PERI_W:0] O_PERI_CLK_EN;
    logic [2:0] O_PWR_STATE;
    logic [3:0] v;
    ccg_chk_t q[$];
    ccg_chk_t c;
    int failures = 0, total_checks = 0, per = 0, cyc = 0, seed = 74;
    // device under test with a short stabilization count
    ccg_clock_ctrl #(.OST_TICKS(8)) i_dut (.I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_HSEL(I_HSEL),
        .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HSIZE(I_HSIZE), .I_HWDATA(I_HWDATA),
        .I_HREADY(O_HREADYOUT), .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP),
        .I_SUB_TICK(I_SUB_TICK), .I_WAKE(I_WAKE), .O_MAIN_OSC_EN(O_MAIN_OSC_EN), .O_MAIN_FB_OFF(O_MAIN_FB_OFF),
        .O_SUB_FB_OFF(O_SUB_FB_OFF), .O_PLL_RUN(O_PLL_RUN), .O_PLL_MULT(O_PLL_MULT), .O_RTO_STOP(O_RTO_STOP),
        .O_CPU_CLK_EN(O_CPU_CLK_EN), .O_SYS_CLK_EN(O_SYS_CLK_EN), .O_PERI_CLK_EN(O_PERI_CLK_EN),
        .O_SYSTEM_CLOCK_OUT_PIN_O(O_SYSTEM_CLOCK_OUT_PIN_O), .O_SYSTEM_CLOCK_OUT_PIN_OE(O_SYSTEM_CLOCK_OUT_PIN_OE), .O_PWR_STATE(O_PWR_STATE));
    ccg_osc_model i_osc (.clk(I_CLK_SYS), .i_slow(slow), .o_sub_tick(I_SUB_TICK));
    // clock and hang guard
    initial begin
        forever #2.5 I_CLK_SYS = ~I_CLK_SYS;
    end
    always @(posedge I_CLK_SYS) begin
        cyc <= cyc + 1;
        if (cyc == 70000) begin
            failures++;
            wrap_up();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic note(input logic [1:0] k, input logic [31:0] m, input logic [31:0] e);
        q.push_back({k, m, e});
        for (int i = 0; i < 400 && k == 2'h1 && q.size() > 0; i++) @(posedge I_CLK_SYS);
    endtask
    // watcher: 0 read data, 1 system tick spacing, 2 pin and pll levels
    always @(negedge I_CLK_SYS) begin
        if (q.size() > 0) begin
            c = q[0];
            if (c.k == 2'h0 && rdp) begin
                c = q.pop_front();
                check(O_HRDATA & c.m, c.e);
            end else if (c.k == 2'h1 && O_SYS_CLK_EN) begin
                c = q.pop_front();
                check(32'(per), c.e);
            end else if (c.k == 2'h2) begin
                c = q.pop_front();
                check({25'h0, O_RTO_STOP, O_SUB_FB_OFF, O_MAIN_FB_OFF, O_SYSTEM_CLOCK_OUT_PIN_OE, O_MAIN_OSC_EN, O_PLL_RUN,
                    O_PLL_MULT} & c.m, c.e);
            end
        end
        per = O_SYS_CLK_EN ? 1 : per + 1;
    end
    // one single transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        I_HSEL <= 1'b1;
        I_HADDR <= {20'h0, a};
        I_HTRANS <= CCG_HTRANS_NONSEQ;
        I_HWRITE <= w;
        do @(posedge I_CLK_SYS); while (O_HREADYOUT !== 1'b1);
        I_HSEL <= 1'b0;
        I_HTRANS <= 2'h0;
        I_HWDATA <= d;
        rdp <= !w;
        do @(posedge I_CLK_SYS); while (O_HREADYOUT !== 1'b1);
        rdp <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        note(2'h0, m, e);
        bus(1'b0, a, 32'h0);
    endtask
    // every select code; 6 and 7 leave divide-by-32
    task automatic sweep(input int f);
        for (int k = 0; k < 8; k++) begin
            bus(1'b1, CCG_PCC_ADDR, 32'(k));
            repeat (300) @(posedge I_CLK_SYS);
            note(2'h1, 32'hFFFF, 32'(f << (k > 5 ? 5 : k)));
        end
        rd(CCG_PCC_ADDR, 32'hFF, 32'h05);
        bus(1'b1, CCG_PCC_ADDR, 32'h03);
    endtask
    // enter a low power state, check it, wake back to run
    task automatic mode(input logic [1:0] cm, input logic [2:0] s);
        // keep the clock output enabled while changing mode
        bus(1'b1, CCG_MODE_ADDR, {27'h0, 1'b1, 2'h0, cm});
        repeat (4) @(posedge I_CLK_SYS);
        rd(CCG_STAT_ADDR, 32'h7, 32'(s));
        if (cm == CCG_CMD_HALT) note(2'h1, 32'hFFFF, 32'h20);
        I_WAKE <= 1'b1;
        @(posedge I_CLK_SYS);
        I_WAKE <= 1'b0;
        repeat (80) @(posedge I_CLK_SYS);
        rd(CCG_STAT_ADDR, 32'h7, 32'h1);
        $display("mode %0d test done", cm);
    endtask
    initial begin
        repeat (8) @(posedge I_CLK_SYS);
        I_RST_N <= 1'b1;
        @(posedge I_CLK_SYS);
        note(2'h2, 32'h8, 32'h0);
        rd(CCG_PLL_CTL_ADDR, 32'hFF, 32'h01);
        rd(CCG_PCC_ADDR, 32'hFF, 32'h03);
        rd(12'h100, 32'hFFFFFFFF, 32'h0);
        repeat (80) @(posedge I_CLK_SYS);
        rd(CCG_STAT_ADDR, 32'h87, 32'h81);
        for (int i = 0; i < 6; i++) begin
            v = 4'($random(seed)) & 4'hD;
            bus(1'b1, CCG_PLL_CTL_ADDR, {28'h0, v});
            rd(CCG_PLL_CTL_ADDR, 32'hFF, {29'h0, v[2:0]});
        end
        bus(1'b1, CCG_PLL_CTL_ADDR, 32'h05);
        note(2'h2, 32'h40, 32'h40);
        bus(1'b1, CCG_PCC_ADDR, 32'hA3);
        note(2'h2, 32'h30, 32'h30);
        bus(1'b1, CCG_PCC_ADDR, 32'h03);
        bus(1'b1, CCG_PLL_CTL_ADDR, 32'h01);
        $display("reset and register test done");
        sweep(4);
        // run first, select after 200 us
        repeat (40000) @(posedge I_CLK_SYS);
        bus(1'b1, CCG_PLL_CTL_ADDR, 32'h03);
        @(posedge I_CLK_SYS);
        note(2'h2, 32'h3, 32'h3);
        sweep(1);
        bus(1'b1, CCG_PLL_CTL_ADDR, 32'h01);
        repeat (8) @(posedge I_CLK_SYS);
        bus(1'b1, CCG_PLL_CTL_ADDR, 32'h00);
        note(2'h2, 32'h3, 32'h0);
        $display("pll test done");
        bus(1'b1, CCG_MODE_ADDR, 32'h10);
        note(2'h2, 32'h8, 32'h8);
        // pll already stopped before idle and stop
        for (int k = 1; k < 4; k++) mode(2'(k), 3'(k + 1));
        bus(1'b1, CCG_PCC_ADDR, 32'h43);
        repeat (100) @(posedge I_CLK_SYS);
        note(2'h2, 32'h4, 32'h4);
        bus(1'b1, CCG_PCC_ADDR, 32'h4B);
        repeat (100) @(posedge I_CLK_SYS);
        rd(CCG_PCC_ADDR, 32'hFF, 32'h5B);
        note(2'h2, 32'h4, 32'h0);
        mode(CCG_CMD_IDLE, CCG_ST_SIDLE);
        slow <= 1'b0;
        bus(1'b1, CCG_PCC_ADDR, 32'h0B);
        repeat (100) @(posedge I_CLK_SYS);
        bus(1'b1, CCG_PCC_ADDR, 32'h03);
        repeat (20) @(posedge I_CLK_SYS);
        rd(CCG_PCC_ADDR, 32'hFF, 32'h03);
        $display("subclock test done");
        wrap_up();
    end
    task automatic wrap_up();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
endmodule
bind ccg_clock_ctrl ccg_checker i_chk (.I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .O_HREADYOUT(O_HREADYOUT),
    .O_HRESP(O_HRESP), .O_MAIN_OSC_EN(O_MAIN_OSC_EN), .O_PLL_RUN(O_PLL_RUN), .O_PLL_MULT(O_PLL_MULT),
    .O_CPU_CLK_EN(O_CPU_CLK_EN), .O_SYS_CLK_EN(O_SYS_CLK_EN), .O_PERI_CLK_EN(O_PERI_CLK_EN),
    .O_SYSTEM_CLOCK_OUT_PIN_O(O_SYSTEM_CLOCK_OUT_PIN_O), .O_PWR_STATE(O_PWR_STATE));
`default_nettype wire
